// file: rtl/ckc_pkg.sv
// package: register map, field positions, reset values and counts of the clock control block
package ckc_pkg;
   localparam logic [7:0]  CKC_ADR_CONTROL   = 8'h00;
   localparam logic [7:0]  CKC_ADR_CONFIG    = 8'h04;
   // control register field positions
   localparam int          CR_INT_EN         = 0;
   localparam int          CR_INT_RDY        = 1;
   localparam int          CR_TRIM_LSB       = 3;
   localparam int          CR_CAL_LSB        = 8;
   localparam int          CR_EXT_EN         = 16;
   localparam int          CR_EXT_RDY        = 17;
   localparam int          CR_EXT_BYP        = 18;
   localparam int          CR_FAIL_DET       = 19;
   localparam int          CR_PLL_EN         = 24;
   localparam int          CR_PLL_LOCK       = 25;
   // configuration register field positions
   localparam int          CF_SEL_LSB        = 0;
   localparam int          CF_STAT_LSB       = 2;
   localparam int          CF_CORE_LSB       = 4;
   localparam int          CF_SLOW_LSB       = 8;
   localparam int          CF_FAST_LSB       = 11;
   localparam int          CF_CONV_LSB       = 14;
   localparam int          CF_PLL_SRC        = 16;
   localparam int          CF_PLL_PRE        = 17;
   localparam int          CF_MUL_LSB        = 18;
   localparam int          CF_USB_DIV        = 22;
   localparam int          CF_CLKOUT_LSB     = 24;
   // reset values
   localparam logic [4:0]  TRIM_RESET        = 5'h10;
   localparam logic [31:0] CONFIG_RESET      = 32'h00000000;
   // system clock sources
   localparam logic [1:0]  SRC_INT           = 2'h0;
   localparam logic [1:0]  SRC_EXT           = 2'h1;
   localparam logic [1:0]  SRC_PLL           = 2'h2;
   // oscillator cycles from enable clear to ready drop
   localparam logic [2:0]  RDY_DROP_CYCLES   = 3'h6;
   // system clock cycles a source switch takes; cfg access waits 1 or 2
   localparam logic [1:0]  SWITCH_CYCLES     = 2'h2;
   localparam logic [3:0]  MUL_MAX_CODE      = 4'hF;
   localparam logic [4:0]  MUL_MAX_FACTOR    = 5'h10;
   localparam logic [4:0]  MUL_OFFSET        = 5'h02;
endpackage

// file: rtl/ckc_ctrl.sv
// clock source selection, oscillator enables and bus prescalers behind two wishbone registers
//
// The Wishbone slave port was chosen for this implementation.
`timescale 1ns/100ps
module ckc_ctrl
   import ckc_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        int_osc_stable_i,
   input  wire logic        ext_osc_stable_i,
   input  wire logic        int_osc_tick_i,
   input  wire logic        ext_osc_tick_i,
   input  wire logic        pll_lock_i,
   input  wire logic [7:0]  int_osc_factory_cal_i,
   input  wire logic        low_power_entry_i,
   input  wire logic        low_power_exit_i,
   input  wire logic        ext_osc_fail_i,
   input  wire logic        usb_clock_on_i,
   output logic             int_osc_enable_o,
   output logic             ext_osc_enable_o,
   output logic             ext_osc_bypass_o,
   output logic             pll_enable_o,
   output logic             failure_detector_active_o,
   output logic [7:0]       int_osc_freq_code_o,
   output logic             pll_input_select_o,
   output logic             pll_ext_predivider_o,
   output logic [4:0]       pll_factor_o,
   output logic             usb_clock_divider_o,
   output logic [2:0]       clock_output_select_o,
   output logic [1:0]       system_clock_source_o,
   output logic             core_bus_tick_o,
   output logic             slow_periph_tick_o,
   output logic             fast_periph_tick_o,
   output logic             converter_tick_o
);

   typedef enum logic {CKC_BUS_IDLE, CKC_BUS_ACK} ckc_bus_e;

   function automatic logic [8:0] core_term(input logic [3:0] code);
      logic [8:0] t;
      t = 9'h000;
      if (code[3]) begin
         unique case (code[2:0])
            3'h0:    t = 9'h001;
            3'h1:    t = 9'h003;
            3'h2:    t = 9'h007;
            3'h3:    t = 9'h00F;
            3'h4:    t = 9'h03F;
            3'h5:    t = 9'h07F;
            3'h6:    t = 9'h0FF;
            3'h7:    t = 9'h1FF;
         endcase
      end
      return t;
   endfunction

   function automatic logic [3:0] periph_term(input logic [2:0] code);
      logic [3:0] t;
      t = 4'h0;
      if (code[2]) begin
         unique case (code[1:0])
            2'h0:    t = 4'h1;
            2'h1:    t = 4'h3;
            2'h2:    t = 4'h7;
            2'h3:    t = 4'hF;
         endcase
      end
      return t;
   endfunction

   // true when the given source is in use or requested, directly or via the pll
   function automatic logic src_in_use(input logic [1:0] src, input logic [1:0] act,
                                       input logic [1:0] req, input logic pll_from_ext);
      logic via_pll;
      via_pll = (act == SRC_PLL) || (req == SRC_PLL);
      return (act == src) || (req == src) || (via_pll && (pll_from_ext == (src == SRC_EXT)));
   endfunction

   // ---------------- bus slave ----------------
   ckc_bus_e    bus_state_ff,  nxt_bus_state;
   logic [31:0] rdata_ff,      nxt_rdata;
   logic [31:0] reg_cr;
   logic [31:0] reg_cf;
   logic        req;
   logic        hit_cr;
   logic        hit_cf;
   logic        wr_cr;
   logic        wr_cf;
   logic [31:0] bmask;
   logic [1:0]  switch_cnt_ff;

   assign req    = wb_cyc_i && wb_stb_i;
   assign hit_cr = (wb_adr_i == CKC_ADR_CONTROL);
   assign hit_cf = (wb_adr_i == CKC_ADR_CONFIG);
   assign bmask  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   assign wr_cr  = (bus_state_ff == CKC_BUS_ACK) && req && wb_we_i && hit_cr;
   assign wr_cf  = (bus_state_ff == CKC_BUS_ACK) && req && wb_we_i && hit_cf;

   always_comb begin
      nxt_bus_state = CKC_BUS_IDLE;
      nxt_rdata     = rdata_ff;
      unique case (bus_state_ff)
         CKC_BUS_IDLE: begin
            // config access stalls while a source switch is under way
            if (req && !(hit_cf && (switch_cnt_ff != 2'h0))) begin
               nxt_bus_state = CKC_BUS_ACK;
               nxt_rdata     = hit_cr ? reg_cr : (hit_cf ? reg_cf : 32'h00000000);
            end
         end
         CKC_BUS_ACK: nxt_bus_state = CKC_BUS_IDLE;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bus_state_ff <= CKC_BUS_IDLE;
         rdata_ff     <= 32'h00000000;
      end else begin
         bus_state_ff <= nxt_bus_state;
         rdata_ff     <= nxt_rdata;
      end
   end

   assign wb_ack_o = (bus_state_ff == CKC_BUS_ACK);
   assign wb_dat_o = rdata_ff;

   // ---------------- oscillator ready flags ----------------
   logic [1:0] osc_en;
   logic [1:0] osc_stable;
   logic [1:0] osc_tick;
   logic [1:0] osc_rdy_ff;
   logic [2:0] osc_cnt_ff [2];

   assign osc_stable = {ext_osc_stable_i, int_osc_stable_i};
   assign osc_tick   = {ext_osc_tick_i, int_osc_tick_i};

   for (genvar g = 0; g < 2; g++) begin : g_rdy
      logic       nxt_rdy;
      logic [2:0] nxt_cnt;
      always_comb begin
         nxt_rdy = osc_rdy_ff[g];
         nxt_cnt = osc_cnt_ff[g];
         if (osc_en[g]) begin
            nxt_cnt = 3'h0;
            nxt_rdy = osc_stable[g];
         end else if (osc_rdy_ff[g] && osc_tick[g]) begin
            nxt_cnt = osc_cnt_ff[g] + 3'h1;
            if (nxt_cnt == RDY_DROP_CYCLES) begin
               nxt_rdy = 1'b0;
            end
         end
      end
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            osc_rdy_ff[g] <= 1'b0;
            osc_cnt_ff[g] <= 3'h0;
         end else begin
            osc_rdy_ff[g] <= nxt_rdy;
            osc_cnt_ff[g] <= nxt_cnt;
         end
      end
   end

   // ---------------- control and configuration state ----------------
   logic        int_en_ff,   nxt_int_en;
   logic        ext_en_ff,   nxt_ext_en;
   logic        byp_ff,      nxt_byp;
   logic        det_en_ff,   nxt_det_en;
   logic        pll_en_ff,   nxt_pll_en;
   logic        lock_ff;
   logic        det_act_ff;
   logic [4:0]  trim_ff,     nxt_trim;
   logic [7:0]  cal_ff;
   logic        cal_load_ff;
   logic [1:0]  sel_ff,      nxt_sel;
   logic [1:0]  stat_ff,     nxt_stat;
   logic [1:0]  nxt_switch_cnt;
   logic [3:0]  core_ff,     nxt_core;
   logic [2:0]  slow_ff,     nxt_slow;
   logic [2:0]  fast_ff,     nxt_fast;
   logic [1:0]  conv_ff,     nxt_conv;
   logic        src_ff,      nxt_src;
   logic        pre_ff,      nxt_pre;
   logic [3:0]  mul_ff,      nxt_mul;
   logic        usb_ff,      nxt_usb;
   logic [2:0]  clkout_ff,   nxt_clkout;
   logic [31:0] cr_new;
   logic [31:0] cf_new;
   logic        fed_fail;
   logic        tgt_ready;

   assign osc_en = {ext_en_ff, int_en_ff};

   assign reg_cr = {6'h00, lock_ff, pll_en_ff, 4'h0, det_en_ff, byp_ff, osc_rdy_ff[1], ext_en_ff,
                    cal_ff, trim_ff, 1'b0, osc_rdy_ff[0], int_en_ff};
   assign reg_cf = {5'h00, clkout_ff, 1'b0, usb_ff, mul_ff, pre_ff, src_ff, conv_ff, fast_ff,
                    slow_ff, core_ff, stat_ff, sel_ff};
   assign cr_new = (reg_cr & ~bmask) | (wb_dat_i & bmask);
   assign cf_new = (reg_cf & ~bmask) | (wb_dat_i & bmask);

   // failure of an external oscillator that feeds the system clock
   assign fed_fail = ext_osc_fail_i && det_act_ff &&
                     ((stat_ff == SRC_EXT) || ((stat_ff == SRC_PLL) && src_ff));

   always_comb begin
      unique case (sel_ff)
         SRC_INT: tgt_ready = osc_rdy_ff[0];
         SRC_EXT: tgt_ready = osc_rdy_ff[1];
         SRC_PLL: tgt_ready = lock_ff;
         default: tgt_ready = 1'b0; // forbidden code never switches
      endcase
   end

   always_comb begin
      nxt_int_en  = int_en_ff;
      nxt_ext_en  = ext_en_ff;
      nxt_byp     = byp_ff;
      nxt_det_en  = det_en_ff;
      nxt_pll_en  = pll_en_ff;
      nxt_trim    = trim_ff;
      nxt_sel     = sel_ff;
      nxt_core    = core_ff;
      nxt_slow    = slow_ff;
      nxt_fast    = fast_ff;
      nxt_conv    = conv_ff;
      nxt_src     = src_ff;
      nxt_pre     = pre_ff;
      nxt_mul     = mul_ff;
      nxt_usb     = usb_ff;
      nxt_clkout  = clkout_ff;
      if (wr_cr) begin
         nxt_int_en = cr_new[CR_INT_EN] ||
                      src_in_use(SRC_INT, stat_ff, sel_ff, src_ff);
         nxt_ext_en = cr_new[CR_EXT_EN] ||
                      src_in_use(SRC_EXT, stat_ff, sel_ff, src_ff);
         nxt_pll_en = cr_new[CR_PLL_EN] || (stat_ff == SRC_PLL) || (sel_ff == SRC_PLL);
         if (!ext_en_ff) begin
            nxt_byp = cr_new[CR_EXT_BYP];
         end
         nxt_det_en = cr_new[CR_FAIL_DET];
         nxt_trim   = cr_new[CR_TRIM_LSB +: 5];
      end
      if (wr_cf) begin
         nxt_sel    = cf_new[CF_SEL_LSB +: 2];
         nxt_core   = cf_new[CF_CORE_LSB +: 4];
         nxt_slow   = cf_new[CF_SLOW_LSB +: 3];
         nxt_fast   = cf_new[CF_FAST_LSB +: 3];
         nxt_conv   = cf_new[CF_CONV_LSB +: 2];
         nxt_clkout = cf_new[CF_CLKOUT_LSB +: 3];
         nxt_usb    = cf_new[CF_USB_DIV] || (usb_ff && usb_clock_on_i);
         if (!pll_en_ff) begin
            nxt_src = cf_new[CF_PLL_SRC];
            nxt_pre = cf_new[CF_PLL_PRE];
            nxt_mul = cf_new[CF_MUL_LSB +: 4];
         end
      end
      // hardware events win over a software write in the same cycle
      if (low_power_entry_i) begin
         nxt_pll_en = 1'b0;
         nxt_ext_en = 1'b0;
      end
      if (low_power_exit_i) begin
         nxt_int_en = 1'b1;
         nxt_sel    = SRC_INT;
      end
      if (ext_osc_fail_i && det_act_ff) begin
         nxt_ext_en = 1'b0;
      end
      if (fed_fail) begin
         nxt_int_en = 1'b1;
         nxt_sel    = SRC_INT;
         if (src_ff && (stat_ff == SRC_PLL)) begin
            nxt_pll_en = 1'b0;
         end
      end
   end

   // source switch: status follows select once the target is ready
   always_comb begin
      nxt_stat       = stat_ff;
      nxt_switch_cnt = switch_cnt_ff;
      if (switch_cnt_ff != 2'h0) begin
         nxt_switch_cnt = switch_cnt_ff - 2'h1;
         if (switch_cnt_ff == 2'h1) begin
            nxt_stat = sel_ff;
         end
      end else if ((sel_ff != stat_ff) && tgt_ready) begin
         nxt_switch_cnt = SWITCH_CYCLES;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         int_en_ff     <= 1'b1;
         ext_en_ff     <= 1'b0;
         byp_ff        <= 1'b0;
         det_en_ff     <= 1'b0;
         pll_en_ff     <= 1'b0;
         lock_ff       <= 1'b0;
         det_act_ff    <= 1'b0;
         trim_ff       <= TRIM_RESET;
         cal_ff        <= 8'h00;
         cal_load_ff   <= 1'b1;
         sel_ff        <= CONFIG_RESET[CF_SEL_LSB +: 2];
         stat_ff       <= SRC_INT;
         switch_cnt_ff <= 2'h0;
         core_ff       <= CONFIG_RESET[CF_CORE_LSB +: 4];
         slow_ff       <= CONFIG_RESET[CF_SLOW_LSB +: 3];
         fast_ff       <= CONFIG_RESET[CF_FAST_LSB +: 3];
         conv_ff       <= CONFIG_RESET[CF_CONV_LSB +: 2];
         src_ff        <= CONFIG_RESET[CF_PLL_SRC];
         pre_ff        <= CONFIG_RESET[CF_PLL_PRE];
         mul_ff        <= CONFIG_RESET[CF_MUL_LSB +: 4];
         usb_ff        <= CONFIG_RESET[CF_USB_DIV];
         clkout_ff     <= CONFIG_RESET[CF_CLKOUT_LSB +: 3];
      end else begin
         int_en_ff     <= nxt_int_en;
         ext_en_ff     <= nxt_ext_en;
         byp_ff        <= nxt_byp;
         det_en_ff     <= nxt_det_en;
         pll_en_ff     <= nxt_pll_en;
         lock_ff       <= pll_lock_i && pll_en_ff;
         det_act_ff    <= det_en_ff && osc_rdy_ff[1];
         trim_ff       <= nxt_trim;
         // strap caught on the first edge after release, never by the reset itself
         if (cal_load_ff) begin
            cal_ff <= int_osc_factory_cal_i;
         end
         cal_load_ff   <= 1'b0;
         sel_ff        <= nxt_sel;
         stat_ff       <= nxt_stat;
         switch_cnt_ff <= nxt_switch_cnt;
         core_ff       <= nxt_core;
         slow_ff       <= nxt_slow;
         fast_ff       <= nxt_fast;
         conv_ff       <= nxt_conv;
         src_ff        <= nxt_src;
         pre_ff        <= nxt_pre;
         mul_ff        <= nxt_mul;
         usb_ff        <= nxt_usb;
         clkout_ff     <= nxt_clkout;
      end
   end

   // ---------------- prescaler chain as enable pulses ----------------
   logic [8:0] core_cnt_ff;
   logic [3:0] slow_cnt_ff;
   logic [3:0] fast_cnt_ff;
   logic [2:0] conv_cnt_ff;
   logic       core_tick_ff;
   logic       slow_tick_ff;
   logic       fast_tick_ff;
   logic       conv_tick_ff;
   logic       core_hit;
   logic       slow_hit;
   logic       fast_hit;
   logic       conv_hit;

   // counters keep running across a new code, so a change may cut short or stretch one period
   assign core_hit = (core_cnt_ff >= core_term(core_ff));
   assign slow_hit = core_hit && (slow_cnt_ff >= periph_term(slow_ff));
   assign fast_hit = core_hit && (fast_cnt_ff >= periph_term(fast_ff));
   assign conv_hit = fast_hit && (conv_cnt_ff >= {conv_ff, 1'b1});

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         core_cnt_ff  <= 9'h000;
         slow_cnt_ff  <= 4'h0;
         fast_cnt_ff  <= 4'h0;
         conv_cnt_ff  <= 3'h0;
         core_tick_ff <= 1'b0;
         slow_tick_ff <= 1'b0;
         fast_tick_ff <= 1'b0;
         conv_tick_ff <= 1'b0;
      end else begin
         core_cnt_ff  <= core_hit ? 9'h000 : core_cnt_ff + 9'h001;
         if (core_hit) begin
            slow_cnt_ff <= slow_hit ? 4'h0 : slow_cnt_ff + 4'h1;
            fast_cnt_ff <= fast_hit ? 4'h0 : fast_cnt_ff + 4'h1;
         end
         if (fast_hit) begin
            conv_cnt_ff <= conv_hit ? 3'h0 : conv_cnt_ff + 3'h1;
         end
         core_tick_ff <= core_hit;
         slow_tick_ff <= slow_hit;
         fast_tick_ff <= fast_hit;
         conv_tick_ff <= conv_hit;
      end
   end

   // ---------------- registered analog-side controls ----------------
   logic [7:0] freq_ff;
   logic [4:0] factor_ff;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         freq_ff   <= 8'h00;
         factor_ff <= MUL_OFFSET;
      end else begin
         freq_ff   <= cal_ff + {3'h0, trim_ff};
         factor_ff <= (mul_ff == MUL_MAX_CODE) ? MUL_MAX_FACTOR : {1'b0, mul_ff} + MUL_OFFSET;
      end
   end

   assign int_osc_enable_o          = int_en_ff;
   assign ext_osc_enable_o          = ext_en_ff;
   assign ext_osc_bypass_o          = byp_ff;
   assign pll_enable_o              = pll_en_ff;
   assign failure_detector_active_o = det_act_ff;
   assign int_osc_freq_code_o       = freq_ff;
   assign pll_input_select_o        = src_ff;
   assign pll_ext_predivider_o      = pre_ff;
   assign pll_factor_o              = factor_ff;
   assign usb_clock_divider_o       = usb_ff;
   assign clock_output_select_o     = clkout_ff;
   assign system_clock_source_o           = stat_ff;
   assign core_bus_tick_o           = core_tick_ff;
   assign slow_periph_tick_o        = slow_tick_ff;
   assign fast_periph_tick_o        = fast_tick_ff;
   assign converter_tick_o          = conv_tick_ff;

endmodule

// file: tb/ckc_ctrl_sva.sv
// assertions on the clock control block ports
`timescale 1ns/100ps
module ckc_ctrl_sva
   import ckc_pkg::*;
(
   input wire logic       clk_i,
   input wire logic       rst_i,
   input wire logic       wb_cyc_i,
   input wire logic       wb_stb_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic       wb_ack_o,
   input wire logic       low_power_entry_i,
   input wire logic       low_power_exit_i,
   input wire logic       ext_osc_fail_i,
   input wire logic       usb_clock_on_i,
   input wire logic       int_osc_enable_o,
   input wire logic       ext_osc_enable_o,
   input wire logic       pll_enable_o,
   input wire logic       failure_detector_active_o,
   input wire logic       pll_input_select_o,
   input wire logic       pll_ext_predivider_o,
   input wire logic [4:0] pll_factor_o,
   input wire logic       usb_clock_divider_o,
   input wire logic [1:0] system_clock_source_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
   a_ctrl_no_wait: assert property (
      $rose(wb_cyc_i && wb_stb_i) && wb_adr_i == CKC_ADR_CONTROL |=> wb_ack_o) else $error("control ack late");
   a_cfg_wait_max: assert property ($rose(wb_cyc_i && wb_stb_i) |-> ##[1:3] wb_ack_o) else $error("ack late");
   a_entry_stops: assert property (
      low_power_entry_i |=> !pll_enable_o && !ext_osc_enable_o) else $error("enables kept at entry");
   a_exit_int_on: assert property (low_power_exit_i |=> int_osc_enable_o) else $error("int osc off at exit");
   a_int_src_kept: assert property (system_clock_source_o == SRC_INT |-> int_osc_enable_o) else $error("int osc off");
   a_src_legal: assert property (system_clock_source_o != 2'h3) else $error("illegal source status");
   a_pll_frozen: assert property (
      $past(pll_enable_o, 2) && $past(pll_enable_o) && pll_enable_o |-> $stable(pll_factor_o)
      && $stable(pll_input_select_o) && $stable(pll_ext_predivider_o)) else $error("pll setup changed while on");
   a_usb_div_kept: assert property (
      $past(usb_clock_on_i) && $past(usb_clock_divider_o) |-> usb_clock_divider_o) else $error("usb bit cleared");
   a_pll_used_kept: assert property (
      system_clock_source_o == SRC_PLL && $past(pll_enable_o) && !$past(low_power_entry_i) && !$past(ext_osc_fail_i)
      |-> pll_enable_o) else $error("pll stopped while used");
   c_ext_src: cover property (system_clock_source_o == SRC_EXT);
   c_exit: cover property (low_power_exit_i);
   c_detector: cover property ($rose(failure_detector_active_o));
   c_cfg_wait: cover property ($rose(wb_cyc_i && wb_stb_i) && wb_adr_i == CKC_ADR_CONFIG ##1 !wb_ack_o);
endmodule
bind ckc_ctrl ckc_ctrl_sva u_sva (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_adr_i(wb_adr_i), .wb_ack_o(wb_ack_o), .low_power_entry_i(low_power_entry_i),
   .low_power_exit_i(low_power_exit_i), .ext_osc_fail_i(ext_osc_fail_i), .usb_clock_on_i(usb_clock_on_i),
   .int_osc_enable_o(int_osc_enable_o), .ext_osc_enable_o(ext_osc_enable_o), .pll_enable_o(pll_enable_o),
   .failure_detector_active_o(failure_detector_active_o), .pll_input_select_o(pll_input_select_o),
   .pll_ext_predivider_o(pll_ext_predivider_o), .pll_factor_o(pll_factor_o),
   .usb_clock_divider_o(usb_clock_divider_o), .system_clock_source_o(system_clock_source_o));

// file: tb/ckc_ctrl_tb_top.sv
// self-checking bench of the clock control block
`timescale 1ns/100ps
module ckc_ctrl_tb_top
   import ckc_pkg::*;
;
   logic        clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, tk = 1'b0;
   logic        int_st = 1'b1, ext_st = 1'b0, lock = 1'b0, lp_in = 1'b0, lp_out = 1'b0, fail = 1'b0, usb_on = 1'b0;
   logic [7:0]  wb_adr_i = 8'h00;
   logic [3:0]  wb_sel_i = 4'hF, sl = 4'hF;
   wire  [3:0]  tks;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rq, n;
   logic        wb_ack_o, ien, een, byp, pen, det, psel, ppre, udiv;
   logic [7:0]  fcode;
   logic [4:0]  fac;
   logic [2:0]  clock_output_select;
   logic [1:0]  src;
   int          fails = 0, samples_checked = 0, k, d;
   always #5 clk_i = ~clk_i;
   // tick on every other clock, so a ready drop takes twelve clocks
   always @(posedge clk_i) tk <= ~tk;
   ckc_ctrl uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .int_osc_stable_i(int_st), .ext_osc_stable_i(ext_st), .int_osc_tick_i(tk), .ext_osc_tick_i(tk),
      .pll_lock_i(lock), .int_osc_factory_cal_i(8'h5A), .low_power_entry_i(lp_in), .low_power_exit_i(lp_out),
      .ext_osc_fail_i(fail), .usb_clock_on_i(usb_on), .int_osc_enable_o(ien), .ext_osc_enable_o(een),
      .ext_osc_bypass_o(byp), .pll_enable_o(pen), .failure_detector_active_o(det), .int_osc_freq_code_o(fcode),
      .pll_input_select_o(psel), .pll_ext_predivider_o(ppre), .pll_factor_o(fac), .usb_clock_divider_o(udiv),
      .clock_output_select_o(clock_output_select), .system_clock_source_o(src), .core_bus_tick_o(tks[0]), .slow_periph_tick_o(tks[1]),
      .fast_periph_tick_o(tks[2]), .converter_tick_o(tks[3]));
   task automatic summarize();
      $display("comparisons %0d, mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one classic cycle; a missing ack ends the run
   task automatic acc(input logic we, input logic [7:0] a, input logic [31:0] dat);
      int t;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_sel_i <= sl;
      wb_dat_i <= dat;
      t = 0;
      do begin
         @(posedge clk_i);
         t++;
      end while (wb_ack_o !== 1'b1 && t < 20);
      rq = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      if (wb_ack_o !== 1'b1) begin
         fails++;
         summarize();
      end
   endtask
   task automatic ws(input logic [1:0] s);
      for (k = 0; k < 20 && src !== s; k++) @(posedge clk_i);
      chk(32'(src), 32'(s));
      if (src !== s) begin
         summarize();
      end
   endtask
   // settle first: a running count may straddle a code change
   task automatic cnt(input int w, input int e);
      repeat (520) @(posedge clk_i);
      n = 32'h0;
      repeat (1536) begin
         @(posedge clk_i);
         n = n + 32'(tks[w]);
      end
      chk(n, 32'(e));
   endtask
   initial begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      acc(0, CKC_ADR_CONTROL, 0);
      chk(rq, 32'h00005A83);
      acc(0, CKC_ADR_CONFIG, 0);
      chk(rq, 32'h0);
      acc(0, 8'h08, 0);
      chk(rq, 32'h0);
      chk(32'(fcode), 32'h6A);
      acc(1, CKC_ADR_CONTROL, 32'hFC00FFFD);
      acc(0, CKC_ADR_CONTROL, 0);
      chk(rq, 32'h00005AFB);
      chk(32'(fcode), 32'h79);
      sl = 4'h1;
      acc(1, CKC_ADR_CONTROL, 32'hFFFFFF81);
      acc(0, CKC_ADR_CONTROL, 0);
      chk(rq, 32'h00005A83);
      sl = 4'hF;
      acc(1, CKC_ADR_CONTROL, 32'h000800F9);
      acc(1, CKC_ADR_CONTROL, 32'h000C00F9);
      repeat (2) @(posedge clk_i);
      chk(32'(det), 32'h0);
      chk(32'(byp), 32'h1);
      ext_st <= 1'b1;
      acc(1, CKC_ADR_CONTROL, 32'h000D00F9);
      repeat (4) @(posedge clk_i);
      acc(1, CKC_ADR_CONTROL, 32'h000900F9);
      acc(0, CKC_ADR_CONTROL, 0);
      chk(rq, 32'h000F5AFB);
      chk(32'(det), 32'h1);
      acc(1, CKC_ADR_CONFIG, 32'h1);
      ws(SRC_EXT);
      acc(0, CKC_ADR_CONFIG, 0);
      chk(rq, 32'h5);
      acc(1, CKC_ADR_CONTROL, 32'h000800F8);
      acc(0, CKC_ADR_CONTROL, 0);
      chk(rq, 32'h000F5AFA);
      repeat (16) @(posedge clk_i);
      acc(0, CKC_ADR_CONTROL, 0);
      chk(rq, 32'h000F5AF8);
      fail <= 1'b1;
      @(posedge clk_i);
      fail <= 1'b0;
      repeat (12) @(posedge clk_i);
      chk(32'(een), 32'h0);
      chk(32'(ien), 32'h1);
      ws(SRC_INT);
      acc(0, CKC_ADR_CONFIG, 0);
      chk(rq, 32'h0);
      for (k = 0; k < 16; k++) begin
         acc(1, CKC_ADR_CONFIG, 32'(k) << 18);
         repeat (2) @(posedge clk_i);
         chk(32'(fac), 32'(k == 15 ? 16 : k + 2));
      end
      acc(1, CKC_ADR_CONFIG, 32'h003E0000);
      acc(1, CKC_ADR_CONTROL, 32'h010000F9);
      lock <= 1'b1;
      repeat (3) @(posedge clk_i);
      acc(0, CKC_ADR_CONTROL, 0);
      chk(rq, 32'h03005AFB);
      acc(1, CKC_ADR_CONFIG, 32'h00030002);
      // read lands inside the switch, so it waits two cycles
      acc(0, CKC_ADR_CONFIG, 0);
      chk(rq, 32'h003E000A);
      ws(SRC_PLL);
      acc(0, CKC_ADR_CONFIG, 0);
      chk(rq, 32'h003E000A);
      chk(32'({ppre, psel}), 32'h2);
      acc(1, CKC_ADR_CONTROL, 32'h000000F8);
      repeat (2) @(posedge clk_i);
      chk(32'({pen, ien}), 32'h3);
      lp_in <= 1'b1;
      @(posedge clk_i);
      lp_in <= 1'b0;
      lock <= 1'b0;
      repeat (2) @(posedge clk_i);
      chk(32'(pen), 32'h0);
      lp_out <= 1'b1;
      @(posedge clk_i);
      lp_out <= 1'b0;
      ws(SRC_INT);
      acc(0, CKC_ADR_CONTROL, 0);
      chk(rq, 32'h00005AFB);
      acc(1, CKC_ADR_CONFIG, 32'h00400000);
      usb_on <= 1'b1;
      acc(1, CKC_ADR_CONFIG, 32'h0);
      repeat (2) @(posedge clk_i);
      chk(32'(udiv), 32'h1);
      usb_on <= 1'b0;
      for (k = 0; k < 8; k++) begin
         acc(1, CKC_ADR_CONFIG, 32'(k) << 24);
         repeat (2) @(posedge clk_i);
         chk(32'(clock_output_select), 32'(k));
      end
      for (int c = 7; c < 16; c++) begin
         acc(1, CKC_ADR_CONFIG, 32'(c) << 4);
         d = c < 8 ? 1 : (c < 12 ? 2 << (c - 8) : 64 << (c - 12));
         cnt(0, 1536 / d);
      end
      for (int c = 3; c < 8; c++) begin
         acc(1, CKC_ADR_CONFIG, 32'(c) * 32'h900);
         d = c < 4 ? 1 : 2 << (c - 4);
         cnt(1, 1536 / d);
         cnt(2, 1536 / d);
      end
      for (int c = 0; c < 4; c++) begin
         acc(1, CKC_ADR_CONFIG, 32'(c) << 14);
         cnt(3, 1536 / (2 * c + 2));
      end
      summarize();
   end
endmodule
